// ### core/hwmon_reg_bank.sv
// Indexed register bank of the hardware monitor: index pointer plus data port.
// Assumes host strobes are synchronous one-cycle pulses; the measurement logic
// outside supplies event pulses and consumes the control registers.
`timescale 1ns/1ps
module hwmon_reg_bank
    import hwmon_bank_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE    = DEF_MAKER_CODE,
    parameter logic [7:0] STEPPING_CODE = DEF_STEPPING
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    // Host access port
    input  wire logic       index_wr_i,
    input  wire logic       data_wr_i,
    input  wire logic       data_rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            rdata_valid_o,
    // Voltage-code pins
    input  wire logic [3:0] cpu_voltage_code_i,
    input  wire logic       cpu_voltage_code_bit4_i,
    // Monitor events
    input  wire logic [7:0] status_first_evt_i,
    input  wire logic [7:0] status_second_evt_i,
    input  wire logic [7:0] error_evt_i,
    // Control registers to the monitor
    output logic      [7:0] configuration_o,
    output logic      [7:0] test_mode_o,
    output logic      [7:0] test_digital_value_o,
    output logic      [7:0] special_function_o,
    output logic      [7:0] cpu_voltage_code_o
);
    logic [7:0] index_ptr_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic       vcode_load_r;
    logic [7:0] vcode_r;
    logic [7:0] vcode_nxt;
    logic [7:0] value_limit_r [VL_COUNT];
    logic [7:0] status_first_w;
    logic [7:0] status_second_w;
    logic [7:0] error_debug_w;

    // Address decode of the current pointer
    wire hit_vl_lo_w  = (index_ptr_r >= OFS_VL_LO_FIRST) && (index_ptr_r <= OFS_VL_LO_LAST);
    wire hit_vl_hi_w  = (index_ptr_r >= OFS_VL_HI_FIRST) && (index_ptr_r <= OFS_VL_HI_LAST);
    wire hit_vl_w     = hit_vl_lo_w || hit_vl_hi_w;
    wire hit_maker_w  = (index_ptr_r == OFS_MAKER);
    wire hit_step_w   = (index_ptr_r == OFS_STEPPING);
    wire hit_cfg_w    = (index_ptr_r == OFS_CONFIG);
    wire hit_st1_w    = (index_ptr_r == OFS_STATUS_FIRST);
    wire hit_st2_w    = (index_ptr_r == OFS_STATUS_SEC);
    wire hit_vlow_w   = (index_ptr_r == OFS_VCODE_LOW);
    wire hit_vhigh_w  = (index_ptr_r == OFS_VCODE_HIGH);
    wire hit_tmode_w  = (index_ptr_r == OFS_TEST_MODE);
    wire hit_err_w    = (index_ptr_r == OFS_ERROR_DEBUG);
    wire hit_tval_w   = (index_ptr_r == OFS_TEST_VALUE);
    wire hit_spec_w   = (index_ptr_r == OFS_SPECIAL);

    // Storage slot of a value/limit offset, high range packed after the low one
    wire [5:0] vl_lo_slot_w = 6'(index_ptr_r - OFS_VL_LO_FIRST);
    wire [5:0] vl_hi_slot_w = 6'(index_ptr_r - OFS_VL_HI_FIRST) + VL_HI_BASE;
    wire [5:0] vl_slot_w    = hit_vl_lo_w ? vl_lo_slot_w : vl_hi_slot_w;

    // Write strobes, only the read/write registers take them
    wire wr_vl_w    = data_wr_i && hit_vl_w;
    wire wr_cfg_w   = data_wr_i && hit_cfg_w;
    wire wr_vlow_w  = data_wr_i && hit_vlow_w;
    wire wr_tmode_w = data_wr_i && hit_tmode_w;
    wire wr_tval_w  = data_wr_i && hit_tval_w;
    wire wr_spec_w  = data_wr_i && hit_spec_w;

    // Read strobes that clear sticky flags
    wire rd_st1_w = data_rd_i && hit_st1_w;
    wire rd_st2_w = data_rd_i && hit_st2_w;
    wire rd_err_w = data_rd_i && hit_err_w;

    // Read data selection; unmapped offsets read zero
    wire [7:0] vcode_high_w = {VCODE_HIGH_FIXED, cpu_voltage_code_bit4_i};
    wire [7:0] rd_mux_w =
        hit_vl_w    ? value_limit_r[vl_slot_w] :
        hit_maker_w ? MAKER_CODE :
        hit_step_w  ? STEPPING_CODE :
        hit_cfg_w   ? configuration_o :
        hit_st1_w   ? status_first_w :
        hit_st2_w   ? status_second_w :
        hit_vlow_w  ? vcode_r :
        hit_vhigh_w ? vcode_high_w :
        hit_tmode_w ? test_mode_o :
        hit_err_w   ? error_debug_w :
        hit_tval_w  ? test_digital_value_o :
        hit_spec_w  ? special_function_o :
        RST_ZERO;

    // Index pointer holds until the next index write
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            index_ptr_r <= RST_ZERO;
        end else if (index_wr_i) begin
            index_ptr_r <= wdata_i;
        end
    end

    // Read data captured from the selected register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r  <= RST_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= data_rd_i;
            if (data_rd_i) begin
                rdata_r <= rd_mux_w;
            end
        end
    end

    assign rdata_o       = rdata_r;
    assign rdata_valid_o = rvalid_r;

    // Value and limit storage
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < VL_COUNT; i++) begin
                value_limit_r[i] <= RST_VALUE_LIMIT;
            end
        end else if (wr_vl_w) begin
            value_limit_r[vl_slot_w] <= wdata_i;
        end
    end

    // Voltage-code register: pin levels caught on the first edge after reset
    assign vcode_nxt = wr_vlow_w    ? wdata_i :
                       vcode_load_r ? {RST_VCODE_UPPER, cpu_voltage_code_i} :
                       vcode_r;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vcode_load_r <= 1'b1;
            vcode_r      <= RST_ZERO;
        end else begin
            vcode_load_r <= 1'b0;
            vcode_r      <= vcode_nxt;
        end
    end

    assign cpu_voltage_code_o = vcode_r;

    // Plain read/write control registers
    rw_reg8 #(.WIDTH(8), .RESET_VAL(RST_CONFIG)) u_config (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .wr_en_i  (wr_cfg_w),
        .wdata_i  (wdata_i),
        .value_o  (configuration_o)
    );

    rw_reg8 #(.WIDTH(8), .RESET_VAL(RST_ZERO)) u_test_mode (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .wr_en_i  (wr_tmode_w),
        .wdata_i  (wdata_i),
        .value_o  (test_mode_o)
    );

    rw_reg8 #(.WIDTH(8), .RESET_VAL(RST_ZERO)) u_test_value (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .wr_en_i  (wr_tval_w),
        .wdata_i  (wdata_i),
        .value_o  (test_digital_value_o)
    );

    rw_reg8 #(.WIDTH(8), .RESET_VAL(RST_ZERO)) u_special (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .wr_en_i  (wr_spec_w),
        .wdata_i  (wdata_i),
        .value_o  (special_function_o)
    );

    // Read-only sticky status, never touched by host writes
    sticky_status8 #(.WIDTH(8)) u_status_first (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .set_i    (status_first_evt_i),
        .clear_i  (rd_st1_w),
        .value_o  (status_first_w)
    );

    sticky_status8 #(.WIDTH(8)) u_status_second (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .set_i    (status_second_evt_i),
        .clear_i  (rd_st2_w),
        .value_o  (status_second_w)
    );

    sticky_status8 #(.WIDTH(8)) u_error_debug (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .set_i    (error_evt_i),
        .clear_i  (rd_err_w),
        .value_o  (error_debug_w)
    );

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence vl_write_s;
        data_wr_i && hit_vl_w && !index_wr_i;
    endsequence

    sequence quiet_read_s;
        data_rd_i && !index_wr_i && !data_wr_i;
    endsequence

    index_hold_a: assert property (!index_wr_i |=> $stable(index_ptr_r))
        else $error("index pointer moved without an index write");

    index_load_a: assert property (index_wr_i |=> index_ptr_r == $past(wdata_i))
        else $error("index pointer did not take the written value");

    vl_roundtrip_a: assert property (vl_write_s ##1 quiet_read_s
        |=> rdata_o == $past(wdata_i, 2) && rdata_valid_o)
        else $error("value or limit register read back wrong data");

    // After a read the flags hold only the events of the read cycle
    status_clear_a: assert property (rd_st1_w
        |=> status_first_w == $past(status_first_evt_i))
        else $error("status register not cleared by its read");

    status_keep_a: assert property (data_wr_i && hit_st2_w && !rd_st2_w
        && status_second_evt_i == 8'h00 |=> $stable(status_second_w))
        else $error("write changed a read-only status register");

    maker_read_a: assert property (data_rd_i && hit_maker_w
        |=> rdata_o == MAKER_CODE && rdata_valid_o)
        else $error("maker code read wrong");

    test_write_a: assert property (wr_tmode_w ##1 !wr_tmode_w
        |-> test_mode_o == $past(wdata_i))
        else $error("test mode register did not take the write");

    vcode_load_a: assert property (vcode_load_r && !wr_vlow_w
        |=> cpu_voltage_code_o == {4'h0, $past(cpu_voltage_code_i)})
        else $error("voltage code register missed the pin levels after reset");

    vcode_high_a: assert property (data_rd_i && hit_vhigh_w
        |=> rdata_o == {7'h40, $past(cpu_voltage_code_bit4_i)})
        else $error("upper voltage code register read wrong");

    unmapped_zero_a: assert property (data_rd_i && index_ptr_r == 8'h00
        |=> rdata_o == 8'h00)
        else $error("unmapped offset did not read zero");
endmodule : hwmon_reg_bank

// ### core/rw_reg8.sv
// One host-writable register with a reset value.
// Assumes a single-cycle write strobe synchronous to clock_i.
`timescale 1ns/1ps
module rw_reg8 #(
    parameter int         WIDTH     = 8,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    // Write port
    input  wire logic             wr_en_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Stored value
    output logic      [WIDTH-1:0] value_o
);
    // Load on write, otherwise hold
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            value_o <= RESET_VAL[WIDTH-1:0];
        end else if (wr_en_i) begin
            value_o <= wdata_i;
        end
    end
endmodule : rw_reg8

// ### core/sticky_status8.sv
// Sticky event flags, cleared by a host read, set winning over clear.
// Assumes event inputs are synchronous one-cycle or level pulses.
`timescale 1ns/1ps
module sticky_status8 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    // Events and read-clear
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic             clear_i,
    // Flags
    output logic      [WIDTH-1:0] value_o
);
    // Clear on read, a new event in the same cycle survives
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            value_o <= '0;
        end else begin
            value_o <= (clear_i ? '0 : value_o) | set_i;
        end
    end
endmodule : sticky_status8

// ### shared/hwmon_bank_pkg.sv
// Constants for the indexed hardware-monitor register bank.
// Assumes one host clock and one asynchronous active-low power-on reset.
// Contract
// - Host writes an 8-bit index first; following data access goes to that register.
// - Index is write-only and holds until software writes a new one.
// - Read/write value and limit registers live at 15-3D and 50-59 hex.
// - Interrupt status registers at 41 and 42 hex are read-only, reset 0x00.
// - Fixed read-only maker code at 3E, stepping/version at 3F; writes ignored.
// - Test value register 4C and test mode register 4A are read/write, reset 0x00.
// - Register 47 resets to 0000 high nibble, voltage-code pins 3..0 low nibble.
// - Register 49 reads 1000000 in bits 7..1, bit 0 is voltage-code pin 4.
package hwmon_bank_pkg;
    // Register offsets
    localparam logic [7:0] OFS_VL_LO_FIRST  = 8'h15;
    localparam logic [7:0] OFS_VL_LO_LAST   = 8'h3d;
    localparam logic [7:0] OFS_VL_HI_FIRST  = 8'h50;
    localparam logic [7:0] OFS_VL_HI_LAST   = 8'h59;
    localparam logic [7:0] OFS_MAKER        = 8'h3e;
    localparam logic [7:0] OFS_STEPPING     = 8'h3f;
    localparam logic [7:0] OFS_CONFIG       = 8'h40;
    localparam logic [7:0] OFS_STATUS_FIRST = 8'h41;
    localparam logic [7:0] OFS_STATUS_SEC   = 8'h42;
    localparam logic [7:0] OFS_VCODE_LOW    = 8'h47;
    localparam logic [7:0] OFS_VCODE_HIGH   = 8'h49;
    localparam logic [7:0] OFS_TEST_MODE    = 8'h4a;
    localparam logic [7:0] OFS_ERROR_DEBUG  = 8'h4b;
    localparam logic [7:0] OFS_TEST_VALUE   = 8'h4c;
    localparam logic [7:0] OFS_SPECIAL      = 8'h4f;
    // Value/limit storage: low range 41 bytes, high range 10 bytes
    localparam int         VL_LO_COUNT      = 41;
    localparam int         VL_COUNT         = 51;
    localparam logic [5:0] VL_HI_BASE       = 6'h29;
    // Reset values
    localparam logic [7:0] RST_CONFIG       = 8'h08;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_VALUE_LIMIT  = 8'h00;
    localparam logic [3:0] RST_VCODE_UPPER  = 4'h0;
    localparam logic [6:0] VCODE_HIGH_FIXED = 7'h40;
    // Identity codes: arbitrary neutral values
    localparam logic [7:0] DEF_MAKER_CODE   = 8'ha5;
    localparam logic [7:0] DEF_STEPPING     = 8'h01;
endpackage : hwmon_bank_pkg

// ### tb/hw_monitor_indexed_register_bank_tb.sv
// Self-checking bench for the indexed hardware-monitor register bank.
// Assumes the package and design files are compiled first; drives the host port directly.
`timescale 1ns/1ps
module hw_monitor_indexed_register_bank_tb;
    import hwmon_bank_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary neutral maker code
    localparam logic [7:0] STEP  = 8'h07; // Arbitrary neutral stepping code
    // Design ports
    logic       clock_i, arst_n_i, index_wr_i, data_wr_i, data_rd_i, rdata_valid_o;
    logic       cpu_voltage_code_bit4_i;
    logic [3:0] cpu_voltage_code_i;
    logic [7:0] wdata_i, rdata_o, status_first_evt_i, status_second_evt_i, error_evt_i;
    logic [7:0] configuration_o, test_mode_o, test_digital_value_o;
    logic [7:0] special_function_o, cpu_voltage_code_o;
    // Bench state
    int         failures, checks_done, seed;
    logic [7:0] ptr;
    logic [7:0] model [0:255];

    hwmon_reg_bank #(.MAKER_CODE(MAKER), .STEPPING_CODE(STEP)) i_hwmon_reg_bank (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .index_wr_i(index_wr_i),
        .data_wr_i(data_wr_i), .data_rd_i(data_rd_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
        .cpu_voltage_code_i(cpu_voltage_code_i),
        .cpu_voltage_code_bit4_i(cpu_voltage_code_bit4_i),
        .status_first_evt_i(status_first_evt_i), .status_second_evt_i(status_second_evt_i),
        .error_evt_i(error_evt_i), .configuration_o(configuration_o),
        .test_mode_o(test_mode_o), .test_digital_value_o(test_digital_value_o),
        .special_function_o(special_function_o), .cpu_voltage_code_o(cpu_voltage_code_o));

    // Clock generation
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Host-writable offsets
    function automatic logic is_rw(input logic [7:0] a);
        return (a >= 8'h15 && a <= 8'h3d) || (a >= 8'h50 && a <= 8'h59) ||
               a == 8'h40 || a == 8'h47 || a == 8'h4a || a == 8'h4c || a == 8'h4f;
    endfunction : is_rw

    // Expected read value at an offset
    function automatic logic [7:0] exp_of(input logic [7:0] a);
        if (a == 8'h3e) return MAKER;
        if (a == 8'h3f) return STEP;
        if (a == 8'h49) return {7'b1000000, cpu_voltage_code_bit4_i};
        return model[a];
    endfunction : exp_of

    // Reset contents of the bank
    function automatic void reset_model();
        foreach (model[i]) model[i] = 8'h00;
        model[8'h40] = 8'h08;
        model[8'h47] = {4'h0, cpu_voltage_code_i};
    endfunction : reset_model

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic wr_index(input logic [7:0] a);
        @(posedge clock_i);
        index_wr_i <= 1'b1;
        wdata_i    <= a;
        @(posedge clock_i);
        index_wr_i <= 1'b0;
        wdata_i    <= ~a;
        ptr = a;
    endtask : wr_index

    task automatic wr_data(input logic [7:0] d);
        @(posedge clock_i);
        data_wr_i <= 1'b1;
        wdata_i   <= d;
        @(posedge clock_i);
        data_wr_i <= 1'b0;
        wdata_i   <= ~d;
        if (is_rw(ptr)) model[ptr] = d;
    endtask : wr_data

    task automatic rd();
        logic [7:0] e;
        @(posedge clock_i);
        e = exp_of(ptr); // Pin levels settled before the read edge
        data_rd_i <= 1'b1;
        @(posedge clock_i);
        data_rd_i <= 1'b0;
        if (ptr == 8'h41 || ptr == 8'h42 || ptr == 8'h4b) model[ptr] = 8'h00;
        @(negedge clock_i);
        check("read valid", {7'h00, rdata_valid_o}, 8'h01);
        check($sformatf("reg %h", ptr), rdata_o, e);
        @(negedge clock_i);
        check("valid drop", {7'h00, rdata_valid_o}, 8'h00);
    endtask : rd

    // Data write and read back on consecutive edges
    task automatic wr_rd(input logic [7:0] d);
        @(posedge clock_i);
        data_wr_i <= 1'b1;
        wdata_i   <= d;
        @(posedge clock_i);
        data_wr_i <= 1'b0;
        data_rd_i <= 1'b1;
        wdata_i   <= ~d;
        @(posedge clock_i);
        data_rd_i <= 1'b0;
        if (is_rw(ptr)) model[ptr] = d;
        @(negedge clock_i);
        check("back to back valid", {7'h00, rdata_valid_o}, 8'h01);
        check($sformatf("back to back %h", ptr), rdata_o, exp_of(ptr));
    endtask : wr_rd

    // Control registers seen on their output ports
    task automatic ports_check();
        check("config port", configuration_o, model[8'h40]);
        check("vcode port", cpu_voltage_code_o, model[8'h47]);
        check("test mode port", test_mode_o, model[8'h4a]);
        check("test value port", test_digital_value_o, model[8'h4c]);
        check("special port", special_function_o, model[8'h4f]);
    endtask : ports_check

    task automatic pulse_evt(input int which, input logic [7:0] v);
        @(posedge clock_i);
        case (which)
            0: status_first_evt_i <= v;
            1: status_second_evt_i <= v;
            default: error_evt_i <= v;
        endcase
        @(posedge clock_i);
        status_first_evt_i  <= 8'h00;
        status_second_evt_i <= 8'h00;
        error_evt_i         <= 8'h00;
        model[which == 0 ? 8'h41 : which == 1 ? 8'h42 : 8'h4b] |= v;
    endtask : pulse_evt

    // Hang guard
    initial begin
        repeat (60000) @(posedge clock_i);
        failures++;
        close_out();
    end

    // Main sequence
    initial begin
        logic [7:0] offs [3];
        failures = 0;
        checks_done = 0;
        seed = 29609;
        arst_n_i = 1'b0;
        {index_wr_i, data_wr_i, data_rd_i} = 3'b000;
        wdata_i = 8'h00;
        {status_first_evt_i, status_second_evt_i, error_evt_i} = 24'h0;
        cpu_voltage_code_i = 4'($random(seed));
        cpu_voltage_code_bit4_i = 1'b1;
        offs = '{8'h41, 8'h42, 8'h4b};
        ptr = 8'h00;
        reset_model();
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'b1;
        // Reset values of every offset; first read uses the reset pointer
        rd();
        for (int a = 0; a < 256; a++) begin
            wr_index(8'(a));
            rd();
        end
        ports_check();
        $display("Test reset values done");
        // Random writes everywhere, including read-only and unmapped offsets
        for (int a = 0; a < 256; a++) begin
            wr_index(8'(a));
            wr_data(8'($random(seed)));
            rd();
            rd();
        end
        ports_check();
        $display("Test write and read back done");
        // Write then read on the next edge in both the low and high value/limit ranges
        for (int k = 0; k < 8; k++) begin
            wr_index(k[0] ? 8'h50 + 8'(k) : 8'h15 + 8'(k * 5));
            wr_rd(8'($random(seed)));
        end
        $display("Test back to back done");
        // Sticky status flags collect events and clear on read
        for (int k = 0; k < 3; k++) begin
            pulse_evt(k, 8'($random(seed)) | 8'h81);
            pulse_evt(k, 8'h02);
            wr_index(offs[k]);
            wr_data(8'hff);
            rd();
            rd();
        end
        $display("Test status flags done");
        // Live voltage-code pin 4 in the high code register
        wr_index(8'h49);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_i);
            cpu_voltage_code_bit4_i <= k[0];
            rd();
        end
        $display("Test voltage pin done");
        // Reset in mid-run restores defaults and recaptures the pins
        @(posedge clock_i);
        arst_n_i <= 1'b0;
        cpu_voltage_code_i <= ~cpu_voltage_code_i;
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'b1;
        ptr = 8'h00;
        reset_model();
        // Pins are caught on the first edge after release
        repeat (2) @(negedge clock_i);
        ports_check();
        wr_index(8'h47);
        rd();
        wr_index(8'h3e);
        wr_data(8'h00);
        rd();
        $display("Test second reset done");
        close_out();
    end
endmodule : hw_monitor_indexed_register_bank_tb
